// [common/csfp_cfg.svh]
// Constants of the codec serial framing port
// Assumes: included by the design files
// Contract
// - Word mode: tx end strobe pulses after 16 bits
// - Byte mode: tx end strobe low after first byte
// - Output MSB present before rx frame sync falls
// - Host shifts bits in while tx sync low
// - Tx frame sync low while bits shift in
// - All timing is integer submultiple of master clock
// - Reset loads dividers, adjusts and control register
// - Reset dividers give 8 kHz at 5.184 MHz
// - Control reset: bits 9,7,6,5,2 set, 4,3 clear
// - Select pin plus control bit pick four modes
// - Sync bit zero: independent tx and rx timing
// - Async byte: byte, end low, gap, byte, release
// - Async word: sync low, word, sync high, end pulse
// - Sync: identical primary syncs, no rx secondary
// - Sync byte: both directions move together
// - Sync word: both syncs low together
// - Shift clock is master clock divided by four
// - Low bits both one: secondary after four shift clocks
`ifndef CSFP_CFG_SVH
`define CSFP_CFG_SVH

`define CSFP_BYTE_LAST  4'h7
`define CSFP_WORD_LAST  4'hF
`define CSFP_GAP_LAST   4'h3
`define CSFP_GAP_CLKS   5'h10
`define CSFP_SEC_SCLKS  3'h4
`define CSFP_SEC_CLKS   16
`define CSFP_A_RST      8'h09
`define CSFP_B_RST      8'h24
`define CSFP_ADJ_RST    8'h01
`define CSFP_CTRL_RST   10'h02E4
`define CSFP_CTRL_SYNC  5
`define CSFP_IDX_TXA    4'h0
`define CSFP_IDX_TXADJ  4'h1
`define CSFP_IDX_TXB    4'h2
`define CSFP_IDX_RXA    4'h3
`define CSFP_IDX_RXADJ  4'h4
`define CSFP_IDX_RXB    4'h5
`define CSFP_IDX_CTRL   4'h6
`define CSFP_IDX_STAT   4'h7
`define CSFP_IDX_SEC    4'h8
`define CSFP_IDX_DAC    4'h9

`endif

// [common/csfp_pkg.sv]
// Types of the codec serial framing port
// Assumes: compiled before the design modules
package csfp_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_PRE,
        ST_SHIFT1,
        ST_GAP,
        ST_SHIFT2,
        ST_END
    } csfp_state_e;

    typedef enum logic [1:0]
    {
        ADJ_NONE,
        ADJ_PLUS,
        ADJ_MINUS
    } csfp_adj_e;

    typedef struct packed
    {
        logic [7:0] a;
        logic [7:0] adj;
        logic [7:0] b;
    } csfp_div_s;

endpackage : csfp_pkg

// [rtl/csfp_conv_timer.sv]
// Counter A / counter B conversion timer of one direction
// Assumes: cfg and adj_mode are static between conversions
`timescale 1ns/10ps
`include "csfp_cfg.svh"

module csfp_conv_timer
    import csfp_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      arst_n,
    input  wire csfp_div_s cfg,
    input  wire csfp_adj_e adj_mode,
    output logic           scf_tick,
    output logic           conv_tick
);
    logic [9:0] ca_r;
    logic [9:0] ca_nxt;
    logic [7:0] cb_r;
    logic [7:0] cb_nxt;
    wire  [9:0] nom_w = {1'b0, cfg.a, 1'b0};
    wire  [9:0] ext_w = {{2{cfg.adj[7]}}, cfg.adj};
    wire  [9:0] sum_w = (adj_mode == ADJ_PLUS)  ? nom_w + ext_w :
                        (adj_mode == ADJ_MINUS) ? nom_w - ext_w : nom_w;
    // Negative or zero period clamps to one master clock
    wire  [9:0] adj_w = (sum_w[9] || sum_w == 10'h000) ? 10'h001 : sum_w;

    assign scf_tick  = (ca_r <= 10'h001);
    assign conv_tick = scf_tick && (cb_r <= 8'h01);
    assign ca_nxt    = conv_tick ? adj_w : scf_tick ? nom_w : ca_r - 10'h001;
    assign cb_nxt    = conv_tick ? cfg.b : scf_tick ? cb_r - 8'h01 : cb_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ca_r <= 10'h001;
            cb_r <= 8'h01;
        end
        else
        begin
            ca_r <= ca_nxt;
            cb_r <= cb_nxt;
        end
    end

endmodule : csfp_conv_timer

// [rtl/csfp_serial_port.sv]
// Serial framing port: shift clock, frame syncs, end strobes, timers
// Assumes: CLK is the master clock; host follows the frame syncs
`timescale 1ns/10ps
`include "csfp_cfg.svh"

module csfp_serial_port
    import csfp_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        WORD_SEL,
    input  wire logic        SERIAL_IN_LINE,
    output logic             SERIAL_OUT_LINE,
    output logic             SHIFT_CLK,
    output logic             TX_FRAME_SYNC_N,
    output logic             RX_FRAME_SYNC_N,
    output logic             TX_END_STROBE_N,
    output logic             RX_END_STROBE_N,
    input  wire logic [15:0] ADC_DATA,
    output logic             ADC_SAMPLE,
    output logic      [13:0] DAC_DATA,
    output logic             DAC_LOAD,
    output logic             TX_FILT_CLK,
    output logic             RX_FILT_CLK
);
    // =========================================================
    // Functions
    // =========================================================
    function automatic csfp_adj_e adj_decode(input logic [1:0] lsb);
        csfp_adj_e m;
        m = (lsb == 2'b01) ? ADJ_PLUS : (lsb == 2'b10) ? ADJ_MINUS : ADJ_NONE;
        return m;
    endfunction : adj_decode

    function automatic logic is_shift(input csfp_state_e s);
        return (s == ST_SHIFT1) || (s == ST_SHIFT2);
    endfunction : is_shift

    // =========================================================
    // Registers
    // =========================================================
    csfp_div_s   tx_div_r;
    csfp_div_s   rx_div_r;
    logic [9:0]  ctrl_r;
    logic [15:0] rdata_r;
    logic [15:0] rd_mux_w;
    logic [15:0] stat_w;
    wire         wr_txa   = WR && (ADDR == `CSFP_IDX_TXA);
    wire         wr_txadj = WR && (ADDR == `CSFP_IDX_TXADJ);
    wire         wr_txb   = WR && (ADDR == `CSFP_IDX_TXB);
    wire         wr_rxa   = WR && (ADDR == `CSFP_IDX_RXA);
    wire         wr_rxadj = WR && (ADDR == `CSFP_IDX_RXADJ);
    wire         wr_rxb   = WR && (ADDR == `CSFP_IDX_RXB);
    wire         wr_ctrl  = WR && (ADDR == `CSFP_IDX_CTRL);
    wire         sync_w   = ctrl_r[`CSFP_CTRL_SYNC];
    wire         byte_w   = !WORD_SEL;

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tx_div_r <= '{`CSFP_A_RST, `CSFP_ADJ_RST, `CSFP_B_RST};
            rx_div_r <= '{`CSFP_A_RST, `CSFP_ADJ_RST, `CSFP_B_RST};
            ctrl_r   <= `CSFP_CTRL_RST;
        end
        else
        begin
            if (wr_txa)   tx_div_r.a   <= WDATA[7:0];
            if (wr_txadj) tx_div_r.adj <= WDATA[7:0];
            if (wr_txb)   tx_div_r.b   <= WDATA[7:0];
            if (wr_rxa)   rx_div_r.a   <= WDATA[7:0];
            if (wr_rxadj) rx_div_r.adj <= WDATA[7:0];
            if (wr_rxb)   rx_div_r.b   <= WDATA[7:0];
            if (wr_ctrl)  ctrl_r       <= WDATA[9:0];
        end
    end

    // =========================================================
    // Shift clock divider
    // =========================================================
    logic [1:0] div_r;
    wire  [1:0] div_nxt = div_r + 2'h1;
    wire        sc_rise = (div_r == 2'h1);
    wire        sc_fall = (div_r == 2'h3);

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            div_r     <= 2'h0;
            SHIFT_CLK <= 1'b0;
        end
        else
        begin
            div_r     <= div_nxt;
            SHIFT_CLK <= div_nxt[1];
        end
    end

    // =========================================================
    // Conversion timers
    // =========================================================
    csfp_adj_e adj_mode_r;
    logic      tx_scf;
    logic      tx_conv;
    logic      rx_scf;
    logic      rx_conv;

    csfp_conv_timer u_tx_timer
    (
        .clk       (CLK),
        .arst_n    (ARST_N),
        .cfg       (tx_div_r),
        .adj_mode  (adj_mode_r),
        .scf_tick  (tx_scf),
        .conv_tick (tx_conv)
    );

    csfp_conv_timer u_rx_timer
    (
        .clk       (CLK),
        .arst_n    (ARST_N),
        .cfg       (rx_div_r),
        .adj_mode  (adj_mode_r),
        .scf_tick  (rx_scf),
        .conv_tick (rx_conv)
    );

    // Synchronous mode leaves the rx counters unused
    wire rx_conv_eff = sync_w ? tx_conv : rx_conv;
    wire rx_scf_eff  = sync_w ? tx_scf  : rx_scf;

    // =========================================================
    // Frame sequencers, index 0 transmit, 1 receive
    // =========================================================
    logic [1:0] go_w;
    logic [1:0] start_w;
    logic [1:0] done_w;
    logic [1:0] shifting_w;
    logic [1:0] fs_n_w;
    logic [1:0] end_n_w;
    logic       tx_pend_r;
    logic       rx_pend_r;
    logic       sec_pend_r;
    logic       tx_sec_r;
    logic [2:0] sec_wait_r;
    wire        sec_go_w = sc_rise && (sec_wait_r == 3'h1);

    assign go_w[0] = tx_pend_r || sec_pend_r;
    // Receive frame tracks the primary transmit frame when synchronous
    assign go_w[1] = sync_w ? (go_w[0] && !sec_pend_r && start_w[0])
                            : rx_pend_r;

    for (genvar d = 0; d < 2; d++)
    begin : g_dir
        csfp_state_e st_r;
        csfp_state_e st_nxt;
        logic [3:0]  cnt_r;
        logic [3:0]  cnt_nxt;
        logic        fs_n_r;
        logic        end_n_r;
        wire  [3:0]  seg_last = byte_w ? `CSFP_BYTE_LAST : `CSFP_WORD_LAST;
        wire         last     = (cnt_r == seg_last);

        always_comb
        begin
            st_nxt  = st_r;
            cnt_nxt = cnt_r;
            if (sc_rise)
            begin
                cnt_nxt = cnt_r + 4'h1;
                case (st_r)
                    ST_IDLE:
                    begin
                        cnt_nxt = 4'h0;
                        if (go_w[d])
                            st_nxt = ST_PRE;
                    end
                    ST_PRE:
                    begin
                        cnt_nxt = 4'h0;
                        st_nxt  = ST_SHIFT1;
                    end
                    ST_SHIFT1:
                    begin
                        if (last)
                        begin
                            cnt_nxt = 4'h0;
                            st_nxt  = byte_w ? ST_GAP : ST_END;
                        end
                    end
                    ST_GAP:
                    begin
                        if (cnt_r == `CSFP_GAP_LAST)
                        begin
                            cnt_nxt = 4'h0;
                            st_nxt  = ST_SHIFT2;
                        end
                    end
                    ST_SHIFT2:
                    begin
                        if (last)
                            st_nxt = ST_IDLE;
                    end
                    ST_END:  st_nxt = ST_IDLE;
                    default: st_nxt = ST_IDLE;
                endcase
            end
        end

        always_ff @(posedge CLK or negedge ARST_N)
        begin
            if (!ARST_N)
            begin
                st_r    <= ST_IDLE;
                cnt_r   <= 4'h0;
                fs_n_r  <= 1'b1;
                end_n_r <= 1'b1;
            end
            else
            begin
                st_r    <= st_nxt;
                cnt_r   <= cnt_nxt;
                fs_n_r  <= !is_shift(st_nxt);
                end_n_r <= !((st_nxt == ST_GAP) || (st_nxt == ST_SHIFT2)
                             || (st_nxt == ST_END));
            end
        end

        assign start_w[d]    = sc_rise && (st_r == ST_IDLE) && go_w[d];
        assign done_w[d]     = sc_rise && last && ((st_r == ST_SHIFT2)
                               || ((st_r == ST_SHIFT1) && !byte_w));
        assign shifting_w[d] = is_shift(st_r);
        assign fs_n_w[d]     = fs_n_r;
        assign end_n_w[d]    = end_n_r;
    end

    assign TX_FRAME_SYNC_N = fs_n_w[0];
    assign RX_FRAME_SYNC_N = fs_n_w[1];
    assign TX_END_STROBE_N = end_n_w[0];
    assign RX_END_STROBE_N = end_n_w[1];

    // =========================================================
    // Frame requests and secondary transfers
    // =========================================================
    logic [15:0] tx_sh_r;
    logic [15:0] rx_sh_r;
    logic [15:0] adc_hold_r;
    logic [15:0] sec_word_r;
    wire         prim_done = done_w[0] && !tx_sec_r;
    wire         want_sec  = prim_done && (tx_sh_r[1:0] == 2'b11);

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tx_pend_r  <= 1'b0;
            rx_pend_r  <= 1'b0;
            sec_pend_r <= 1'b0;
            tx_sec_r   <= 1'b0;
            sec_wait_r <= 3'h0;
        end
        else
        begin
            // A conversion in the same cycle as a start stays pending
            tx_pend_r  <= tx_conv || (tx_pend_r && !(start_w[0] && !sec_pend_r));
            rx_pend_r  <= (rx_conv && !sync_w) || (rx_pend_r && !start_w[1] && !sync_w);
            sec_pend_r <= sec_go_w || (sec_pend_r && !start_w[0]);
            if (start_w[0])
                tx_sec_r <= sec_pend_r;
            if (want_sec)
                sec_wait_r <= `CSFP_SEC_SCLKS;
            else if (sc_rise && sec_wait_r != 3'h0)
                sec_wait_r <= sec_wait_r - 3'h1;
        end
    end

    // =========================================================
    // Serial data paths
    // =========================================================
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tx_sh_r    <= 16'h0000;
            rx_sh_r    <= 16'h0000;
            adc_hold_r <= 16'h0000;
            sec_word_r <= 16'h0000;
            DAC_DATA   <= 14'h0000;
            DAC_LOAD   <= 1'b0;
            adj_mode_r <= ADJ_NONE;
        end
        else
        begin
            if (sc_fall && shifting_w[0])
                tx_sh_r <= {tx_sh_r[14:0], SERIAL_IN_LINE};
            if (start_w[1])
                rx_sh_r <= adc_hold_r;
            else if (sc_rise && shifting_w[1])
                rx_sh_r <= {rx_sh_r[14:0], 1'b0};
            if (rx_conv_eff)
                adc_hold_r <= ADC_DATA;
            if (done_w[0] && tx_sec_r)
                sec_word_r <= tx_sh_r;
            if (prim_done)
                DAC_DATA <= tx_sh_r[15:2];
            DAC_LOAD <= prim_done;
            // New adjust request wins over the end-of-period clear
            if (prim_done)
                adj_mode_r <= adj_decode(tx_sh_r[1:0]);
            else if (tx_conv)
                adj_mode_r <= ADJ_NONE;
        end
    end

    assign SERIAL_OUT_LINE = rx_sh_r[15];

    // =========================================================
    // Pins from converter timing and register read port
    // =========================================================
    assign stat_w = {1'b0, rx_pend_r, tx_pend_r, end_n_w, fs_n_w, byte_w, sync_w,
                     adj_mode_r, sec_wait_r, sec_pend_r, tx_sec_r};

    assign rd_mux_w = (ADDR == `CSFP_IDX_TXA)   ? {8'h00, tx_div_r.a}   :
                      (ADDR == `CSFP_IDX_TXADJ) ? {8'h00, tx_div_r.adj} :
                      (ADDR == `CSFP_IDX_TXB)   ? {8'h00, tx_div_r.b}   :
                      (ADDR == `CSFP_IDX_RXA)   ? {8'h00, rx_div_r.a}   :
                      (ADDR == `CSFP_IDX_RXADJ) ? {8'h00, rx_div_r.adj} :
                      (ADDR == `CSFP_IDX_RXB)   ? {8'h00, rx_div_r.b}   :
                      (ADDR == `CSFP_IDX_CTRL)  ? {6'h00, ctrl_r}       :
                      (ADDR == `CSFP_IDX_STAT)  ? stat_w                :
                      (ADDR == `CSFP_IDX_SEC)   ? sec_word_r            :
                      (ADDR == `CSFP_IDX_DAC)   ? {2'h0, DAC_DATA}      : 16'h0000;

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rdata_r     <= 16'h0000;
            ADC_SAMPLE  <= 1'b0;
            TX_FILT_CLK <= 1'b0;
            RX_FILT_CLK <= 1'b0;
        end
        else
        begin
            rdata_r     <= RD ? rd_mux_w : 16'h0000;
            ADC_SAMPLE  <= rx_conv_eff;
            TX_FILT_CLK <= tx_scf;
            RX_FILT_CLK <= rx_scf_eff;
        end
    end

    assign RDATA = rdata_r;

    // =========================================================
    // Assertions
    // =========================================================
    logic [4:0] gap_cnt_r;
    logic       rst_seen_r;

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            gap_cnt_r  <= 5'h00;
            rst_seen_r <= 1'b0;
        end
        else
        begin
            gap_cnt_r  <= (TX_FRAME_SYNC_N && !TX_END_STROBE_N) ? gap_cnt_r + 5'h01 : 5'h00;
            rst_seen_r <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_prim_lsb_ones;
        prim_done && (tx_sh_r[1:0] == 2'b11);
    endsequence

    sequence s_word_last;
        sc_rise && !byte_w && done_w[0];
    endsequence

    chk_word_end_pulse: assert property (s_word_last |=> !TX_END_STROBE_N && TX_FRAME_SYNC_N
        ##4 TX_END_STROBE_N)
        else $error("tx end strobe not pulsed after word");

    chk_byte_end_low: assert property (
        (sc_rise && byte_w && g_dir[0].st_r == ST_SHIFT1 && g_dir[0].last)
        |=> !TX_END_STROBE_N && TX_FRAME_SYNC_N)
        else $error("tx end strobe not low after first byte");

    chk_msb_before_fs: assert property ($fell(RX_FRAME_SYNC_N) |-> $stable(SERIAL_OUT_LINE)
        && SERIAL_OUT_LINE == adc_hold_r[15])
        else $error("output msb not set before rx frame sync");

    chk_fs_low_shift: assert property ((sc_fall && shifting_w[0]) |-> !TX_FRAME_SYNC_N)
        else $error("tx bit sampled while frame sync high");

    chk_gap_width: assert property (($fell(TX_FRAME_SYNC_N) && !TX_END_STROBE_N)
        |-> gap_cnt_r == `CSFP_GAP_CLKS)
        else $error("byte gap pulse not four shift clocks");

    chk_shift_div: assert property ($rose(SHIFT_CLK) |=> !$rose(SHIFT_CLK)[*3]
        ##1 $rose(SHIFT_CLK))
        else $error("shift clock not master clock over four");

    chk_sync_frames: assert property ((sync_w && $fell(RX_FRAME_SYNC_N))
        |-> $fell(TX_FRAME_SYNC_N))
        else $error("sync mode frame syncs not together");

    chk_no_rx_sec: assert property ((sync_w && tx_sec_r && !TX_FRAME_SYNC_N)
        |-> RX_FRAME_SYNC_N)
        else $error("rx frame sync during secondary transfer");

    chk_sec_delay: assert property (s_prim_lsb_ones |-> ##`CSFP_SEC_CLKS sec_go_w)
        else $error("secondary not requested four shift clocks later");

    chk_out_edge: assert property ($changed(SERIAL_OUT_LINE) |-> $past(sc_rise))
        else $error("serial output changed off shift clock rise");

    chk_reset_vals: assert property (!rst_seen_r |-> ctrl_r == `CSFP_CTRL_RST
        && tx_div_r.adj == `CSFP_ADJ_RST && rx_div_r.adj == `CSFP_ADJ_RST
        && tx_div_r.a == `CSFP_A_RST && tx_div_r.b == `CSFP_B_RST)
        else $error("registers not at reset values");

endmodule : csfp_serial_port

// [bench/csfp_host_model.sv]
// Host serial port model: shifts one word in per frame, captures the output
// Assumes: clk is the master clock that also runs the port under test
`timescale 1ns/10ps

module csfp_host_model
(
    input  wire logic        clk,
    input  wire logic        sclk,
    input  wire logic        tx_fs_n,
    input  wire logic        tx_end_n,
    input  wire logic        rx_fs_n,
    input  wire logic        rx_end_n,
    input  wire logic        dout,
    input  wire logic [15:0] tx_word,
    output logic             din,
    output logic      [15:0] rx_word,
    output int               rx_frames
);
    logic       sclk_r;
    logic [3:0] tcnt_r;
    logic [3:0] rcnt_r;
    wire        rise = sclk & ~sclk_r;
    wire        fall = ~sclk & sclk_r;

    initial
    begin
        sclk_r    = 1'b0;
        tcnt_r    = 4'h0;
        rcnt_r    = 4'h0;
        din       = 1'b0;
        rx_word   = 16'h0000;
        rx_frames = 0;
    end

    // Edges are seen one clock late, so the syncs read are settled
    always @(posedge clk)
    begin
        sclk_r <= sclk;
        if (rise && !tx_fs_n)
        begin
            din    <= tx_word[4'hF - tcnt_r];
            tcnt_r <= tcnt_r + 4'h1;
        end
        else if (rise)
            din <= ~din; // Idle line never repeats the last bit
        if (tx_fs_n && tx_end_n)
            tcnt_r <= 4'h0;
        if (fall && !rx_fs_n)
        begin
            rx_word   <= {rx_word[14:0], dout};
            rcnt_r    <= rcnt_r + 4'h1;
            rx_frames <= (rcnt_r == 4'hF) ? rx_frames + 1 : rx_frames;
        end
        if (rx_fs_n && rx_end_n)
            rcnt_r <= 4'h0;
    end
endmodule : csfp_host_model

// [bench/testbench.sv]
// Self-checking bench of the serial framing port against a host model
// Assumes: package, design and host model compiled first
`timescale 1ns/10ps

module testbench;
    logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, word_sel = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, adc = 16'h3C5A, host_word = 16'hA5C4;
    logic [15:0] rdata, rx_word;
    logic [13:0] dac;
    logic        din, dout, sclk, tfs_n, rfs_n, tend_n, rend_n, adc_smp, tfilt;
    int          rx_frames, miscompares = 0, n_tests = 0;

    always #4 clk = ~clk;

    csfp_serial_port csfp_serial_port_i (.CLK(clk), .ARST_N(arst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .WORD_SEL(word_sel),
        .SERIAL_IN_LINE(din), .SERIAL_OUT_LINE(dout), .SHIFT_CLK(sclk),
        .TX_FRAME_SYNC_N(tfs_n), .RX_FRAME_SYNC_N(rfs_n), .TX_END_STROBE_N(tend_n),
        .RX_END_STROBE_N(rend_n), .ADC_DATA(adc), .ADC_SAMPLE(adc_smp), .DAC_DATA(dac),
        .DAC_LOAD(), .TX_FILT_CLK(tfilt), .RX_FILT_CLK());

    csfp_host_model csfp_host_model_i (.clk(clk), .sclk(sclk), .tx_fs_n(tfs_n),
        .tx_end_n(tend_n), .rx_fs_n(rfs_n), .rx_end_n(rend_n), .dout(dout),
        .tx_word(host_word), .din(din), .rx_word(rx_word), .rx_frames(rx_frames));

    // =========
    // Tasks
    task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp, input string s);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask : cmp_v

    task automatic cmp_n(input int got, input int exp, input string s);
        n_tests++;
        if (got != exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s got %0d exp %0d", $time, s, got, exp);
        end
    endtask : cmp_n

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    function automatic logic sig(input int k);
        case (k)
            0: return tfs_n;
            1: return tend_n;
            2: return sclk;
            3: return adc_smp;
            default: return tfilt;
        endcase
    endfunction : sig

    // Counts settled samples while the chosen signal holds v, the current one included
    task automatic run_len(input int k, input logic v, output int n);
        n = 0;
        if (clk)
            @(negedge clk);
        while (sig(k) === v && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
    endtask : run_len

    task automatic frame_chk(input logic wrd, input logic syn);
        int n;
        run_len(0, 1'b0, n);
        run_len(0, 1'b1, n);
        if (syn) cmp_v(16'(rfs_n), 16'h0000, "rx sync");
        run_len(0, 1'b0, n);
        cmp_n(n, wrd ? 64 : 32, "sync low");
        cmp_v(16'({tend_n, rend_n}), 16'h0000, "end low");
        if (wrd)
        begin
            run_len(1, 1'b0, n);
            cmp_n(n, 4, "end pulse");
        end
        else
        begin
            run_len(0, 1'b1, n);
            cmp_n(n, 16, "gap pulse");
            cmp_v(16'(tend_n), 16'h0000, "end held");
            run_len(0, 1'b0, n);
            cmp_n(n, 32, "second byte");
            cmp_v(16'({tend_n, tfs_n}), 16'h0003, "release");
        end
    endtask : frame_chk

    // =========
    // Tests
    task automatic t_regs;
        logic [15:0] d;
        logic [15:0] e [8] = '{16'h0009, 16'h0001, 16'h0024, 16'h0009,
                               16'h0001, 16'h0024, 16'h02E4, 16'h0000};
        int n;
        for (int i = 0; i < 8; i++)
        begin
            rd_reg((i == 7) ? 4'hF : 4'(i), d);
            cmp_v(d, e[i], "reset value");
        end
        wr_reg(4'h1, 16'h0003);
        rd_reg(4'h1, d);
        cmp_v(d, 16'h0003, "adjust write");
        wr_reg(4'h1, 16'h0001);
        run_len(2, 1'b1, n);
        run_len(2, 1'b0, n);
        cmp_n(n, 2, "sclk low");
        run_len(2, 1'b1, n);
        cmp_n(n, 2, "sclk high");
        run_len(4, 1'b0, n);
        run_len(4, 1'b1, n);
        run_len(4, 1'b0, n);
        cmp_n(n + 1, 18, "filter clock period");
        $display("register test done");
    endtask : t_regs

    task automatic t_mode(input logic ws, input logic syn, input logic [15:0] w);
        int n;
        int rf;
        wr_reg(4'h6, syn ? 16'h02E4 : 16'h02C4);
        word_sel  <= ws;
        host_word <= w;
        frame_chk(ws, syn);
        cmp_v(16'(dac), 16'(w[15:2]), "dac word");
        rf = rx_frames;
        n = 0;
        while (rx_frames == rf && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        cmp_v(rx_word, adc, "adc word");
        $display("mode test done: word %0d sync %0d", ws, syn);
    endtask : t_mode

    task automatic t_secondary;
        int n;
        logic [15:0] d;
        @(posedge clk);
        word_sel  <= 1'b1;
        host_word <= 16'h1233;
        frame_chk(1'b1, 1'b1);
        host_word <= 16'h4E71;
        run_len(0, 1'b1, n);
        cmp_v(16'(n < 40), 16'h0001, "secondary start");
        cmp_v(16'(rfs_n), 16'h0001, "rx idle");
        run_len(0, 1'b0, n);
        host_word <= 16'h8880;
        rd_reg(4'h8, d);
        cmp_v(d, 16'h4E71, "secondary word");
        cmp_v(16'(dac), 16'h048C, "dac kept");
        $display("secondary test done");
    endtask : t_secondary

    task automatic t_rate(input logic [3:0] a, input logic [15:0] v, input int p);
        int n;
        wr_reg(a, v);
        repeat (2)
        begin
            run_len(3, 1'b0, n);
            run_len(3, 1'b1, n);
        end
        run_len(3, 1'b0, n);
        cmp_n(n + 1, p, "conversion period");
        $display("rate test done: period %0d", p);
    endtask : t_rate

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // =========
    // Run
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_mode(1'b1, 1'b1, 16'hA5C4);
        t_mode(1'b0, 1'b0, 16'h6B38);
        t_mode(1'b1, 1'b0, 16'hC3D0);
        t_mode(1'b0, 1'b1, 16'h1E6C);
        t_secondary();
        t_rate(4'h6, 16'h02E4, 648);
        t_rate(4'h5, 16'h0012, 648);
        t_rate(4'h6, 16'h02C4, 324);
        final_report();
    end

    initial
    begin
        #300000;
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end
endmodule : testbench
